/* bench/tb.sv */
// testbench for the token host controller
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, rst = 1, cv = 0, bwe = 0, bd = 1;
    logic [1:0] cmd = 2'h0;
    logic [2:0] tok = 3'h0, bt = 3'h0, a;
    wire [15:0] q, dout;
    wire [7:0] own, bown;
    wire busy, done, gr, idn, sn, oen, rwn, doe;
    int num_errors = 0, n_tests = 0;
    always #5 clk = ~clk;
    token_host #(.STROBE_CYC(1)) token_host_i (.i_sys_clk(clk), .i_rst(rst), .i_ce(1'b1),
        .i_cmd_valid(cv), .i_cmd(cmd), .i_cmd_tok(tok), .i_data_in(q), .o_busy(busy),
        .o_done(done), .o_granted(gr), .o_init_done(idn), .o_owned(own),
        .o_token_space_select_n(sn), .o_oe_n(oen), .o_rw_n(rwn), .o_addr(a),
        .o_data_out(dout), .o_data_oe(doe));
    token_dev token_dev_i (.i_sys_clk(clk), .i_sel_n(sn), .i_oe_n(oen), .i_rw_n(rwn),
        .i_addr(a), .i_d(dout), .i_b_we(bwe), .i_b_tok(bt), .i_b_d(bd), .o_q(q), .o_b_own(bown));
    task chk(input logic [7:0] g, input logic [7:0] e);
        n_tests++;
        if (g !== e) begin
            num_errors++;
            $display("MISMATCH %0t got %h exp %h", $time, g, e);
        end
    endtask
    task test_done;
        $display("tests %0d errors %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task op(input logic [1:0] c, input logic [2:0] t);
        int i;
        @(posedge clk);
        #1 cmd = c; tok = t; cv = 1;
        @(posedge clk);
        #1 cv = 0;
        for (i = 0; i < 50 && done !== 1'b1; i++) begin @(posedge clk); #1; end
        if (i == 50) begin num_errors++; test_done; end
    endtask
    task bw(input logic [2:0] t, input logic d);
        @(posedge clk);
        #1 bt = t; bd = d; bwe = 1;
        @(posedge clk);
        #1 bwe = 0;
        repeat (2) @(posedge clk);
        #1;
    endtask
    task t_all;
        for (int k = 0; k < 8; k++) begin op(2'h0, k); chk(gr, 1); end
        chk(own, 8'hFF);
        for (int k = 0; k < 8; k++) op(2'h1, k);
        chk(own, 8'h00);
        $display("all tokens done");
    endtask
    task t_pass;
        op(2'h0, 3'h3);
        bw(3'h3, 0);
        chk(bown, 8'h00);
        op(2'h1, 3'h3);
        repeat (2) @(posedge clk);
        chk(bown, 8'h08);
        op(2'h0, 3'h3);
        chk(gr, 0);
        op(2'h3, 3'h3);
        bw(3'h3, 1);
        bw(3'h3, 0);
        chk(bown, 8'h08);
        $display("token passing done");
    endtask
    initial begin
        repeat (10) @(posedge clk);
        #1 rst = 0;
        for (int k = 0; k < 8; k++) bw(k, 1);
        for (int k = 0; k < 200 && idn !== 1'b1; k++) begin @(posedge clk); #1; end
        if (idn !== 1'b1) begin num_errors++; test_done; end
        chk(own, 8'h00);
        chk(bown, 8'h00);
        $display("init done");
        t_all;
        t_pass;
        test_done;
    end
endmodule
bind token_host token_host_props token_host_props_i (.*);
`default_nettype wire

/* bench/token_dev.sv */
// behavioural model of the shared token block
`default_nettype none
module token_dev (
    input wire logic        i_sys_clk, // clock
    input wire logic        i_sel_n,   // host select
    input wire logic        i_oe_n,    // host read
    input wire logic        i_rw_n,    // host write low
    input wire logic [2:0]  i_addr,    // host token
    input wire logic [15:0] i_d,       // host data
    input wire logic        i_b_we,    // far port write
    input wire logic [2:0]  i_b_tok,   // far port token
    input wire logic        i_b_d,     // far port value
    output logic     [15:0] o_q,       // data to host
    output logic     [7:0]  o_b_own    // far port holdings
);
    // latches start in an arbitrary mix, nothing clears them
    logic [7:0] ra = 8'h5A, rb = 8'hA5, oa = 8'h00;
    initial o_b_own = 8'h00;
    logic [15:0] q_last = 16'h0000;
    wire         rd_en  = !i_sel_n && !i_oe_n;
    // pins answer as soon as select and enable are low, as the real port does;
    // a released bus shows the inverse of the last read, never a held value
    assign o_q = rd_en ? {16{~oa[i_addr]}} : ~q_last;
    always @(posedge i_sys_clk) begin
        if (!i_sel_n && !i_rw_n) ra[i_addr] <= i_d[0];
        if (i_b_we) rb[i_b_tok] <= i_b_d;
        if (rd_en) q_last <= {16{~oa[i_addr]}};
        for (int i = 0; i < 8; i++) begin
            if (!oa[i] && !o_b_own[i]) begin
                if (!ra[i]) oa[i] <= 1'b1;
                else if (!rb[i]) o_b_own[i] <= 1'b1;
            end else if (oa[i] && ra[i]) begin
                oa[i] <= 1'b0;
                o_b_own[i] <= !rb[i];
            end else if (o_b_own[i] && rb[i]) begin
                o_b_own[i] <= 1'b0;
                oa[i] <= !ra[i];
            end
        end
    end
endmodule
`default_nettype wire

/* bench/token_host_props.sv */
// checker for the token host port strobes
`default_nettype none
module token_host_props (
    input wire logic        i_sys_clk,              // clock
    input wire logic        i_rst,                  // reset
    input wire logic        o_busy,                 // busy
    input wire logic        o_granted,              // grant
    input wire logic        o_init_done,            // init done
    input wire logic [7:0]  o_owned,                // owned tokens
    input wire logic        o_token_space_select_n, // select
    input wire logic        o_oe_n,                 // output enable
    input wire logic        o_rw_n,                 // read/write
    input wire logic [2:0]  o_addr,                 // address
    input wire logic [15:0] o_data_out,             // write data
    input wire logic        o_data_oe               // data enable
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);
    wire wr = !o_token_space_select_n && !o_rw_n;
    cmd_write_a: assert property (wr |-> o_oe_n && o_data_oe)
        else $error("write strobe with bad enables");
    read_float_a: assert property (!o_oe_n |-> o_rw_n && !o_data_oe && !o_token_space_select_n)
        else $error("read strobe with bad enables");
    init_one_a: assert property (wr && !o_init_done |-> o_data_out[0])
        else $error("init wrote a zero");
    init_busy_a: assert property (!o_init_done |-> o_busy)
        else $error("not busy during init");
    wr_rd_a: assert property (wr && !o_data_out[0] ##1 o_token_space_select_n |=> !o_oe_n)
        else $error("request not read back");
    release_a: assert property (wr && o_data_out[0] && o_init_done && o_addr == 3'h0
        |-> ##[1:8] !o_owned[0])
        else $error("token kept after write of one");
    stable_a: assert property (!o_token_space_select_n && !$fell(o_token_space_select_n)
        |-> $stable(o_addr) && $stable(o_rw_n))
        else $error("address moved in a strobe");
    cover property (!o_oe_n);
    cover property ($rose(o_granted));
    cover property ($fell(o_owned[0]));
endmodule
`default_nettype wire

/* src/token_host.v */
// host controller driving one port of a dual-port semaphore token block
// Operation
// - host writes one to every token first
// - owner releases token by writing one
// - failed requester withdraws by writing one
// - acquire writes zero then reads back
// - select low, three address lines pick token
`default_nettype none
`include "token_host_regs.vh"
module token_host #(
    parameter STROBE_CYC = `TOK_STROBE_CYC
) (
    input  wire                     i_sys_clk,   // system clock
    input  wire                     i_rst,       // async reset, active high
    input  wire                     i_ce,        // clock enable
    input  wire                     i_cmd_valid, // command strobe
    input  wire [1:0]               i_cmd,       // command code
    input  wire [`TOK_ADDR_W-1:0]   i_cmd_tok,   // token index
    input  wire [`TOK_DATA_W-1:0]   i_data_in,   // data pins from device
    output reg                      o_busy,      // command in progress
    output reg                      o_done,      // one-cycle completion pulse
    output reg                      o_granted,   // acquire result
    output reg                      o_init_done, // all tokens freed since reset
    output reg  [`TOK_COUNT-1:0]    o_owned,     // tokens held by this port
    output reg                      o_token_space_select_n, // select, low active
    output reg                      o_oe_n,      // output enable, low active
    output reg                      o_rw_n,      // high read, low write
    output reg  [`TOK_ADDR_W-1:0]   o_addr,      // token address pins
    output reg  [`TOK_DATA_W-1:0]   o_data_out,  // data pins toward device
    output reg                      o_data_oe    // high while host drives data
);
    // ------------------------------------------------------------
    // states
    // ------------------------------------------------------------
    localparam S_IDLE  = 3'h0;
    localparam S_WR    = 3'h1;
    localparam S_GAP   = 3'h2;
    localparam S_RD    = 3'h3;
    localparam S_FIN   = 3'h4;

    reg [2:0]             state_reg;
    reg [1:0]             cmd_reg;
    reg [7:0]             cnt_reg;
    reg                   init_reg;

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            state_reg              <= S_IDLE;
            cmd_reg                <= 2'h0;
            cnt_reg                <= 8'h00;
            init_reg               <= 1'b0;
            o_busy                 <= 1'b1;
            o_done                 <= 1'b0;
            o_granted              <= 1'b0;
            o_init_done            <= 1'b0;
            o_owned                <= {`TOK_COUNT{1'b0}};
            o_token_space_select_n <= 1'b1;
            o_oe_n                 <= 1'b1;
            o_rw_n                 <= 1'b1;
            o_addr                 <= {`TOK_ADDR_W{1'b0}};
            o_data_out             <= {`TOK_DATA_W{1'b1}};
            o_data_oe              <= 1'b0;
        end else if (i_ce) begin
            o_done <= 1'b0;
            case (state_reg)
            S_IDLE: begin
                o_token_space_select_n <= 1'b1;
                o_oe_n                 <= 1'b1;
                o_rw_n                 <= 1'b1;
                o_data_oe              <= 1'b0;
                if (!init_reg) begin
                    // contents are undefined until written, so free all first
                    cmd_reg   <= `TOK_CMD_INIT;
                    o_addr    <= {`TOK_ADDR_W{1'b0}};
                    o_busy    <= 1'b1;
                    state_reg <= S_WR;
                    cnt_reg   <= 8'h00;
                end else if (i_cmd_valid && i_cmd != `TOK_CMD_INIT) begin
                    cmd_reg   <= i_cmd;
                    o_addr    <= i_cmd_tok;
                    o_busy    <= 1'b1;
                    state_reg <= S_WR;
                    cnt_reg   <= 8'h00;
                end else begin
                    o_busy <= 1'b0;
                end
            end
            S_WR: begin
                // write phase: only bit zero matters to the device
                o_token_space_select_n <= 1'b0;
                o_rw_n                 <= 1'b0;
                o_oe_n                 <= 1'b1;
                o_data_oe              <= 1'b1;
                o_data_out <= (cmd_reg == `TOK_CMD_ACQUIRE) ?
                              {`TOK_DATA_W{1'b0}} : {`TOK_DATA_W{1'b1}};
                if (cnt_reg == STROBE_CYC[7:0]) begin
                    cnt_reg   <= 8'h00;
                    state_reg <= S_GAP;
                end else begin
                    cnt_reg <= cnt_reg + 8'h01;
                end
            end
            S_GAP: begin
                // deselect between cycles so the device relatches the read value
                o_token_space_select_n <= 1'b1;
                o_rw_n                 <= 1'b1;
                o_data_oe              <= 1'b0;
                if (cmd_reg == `TOK_CMD_ACQUIRE) begin
                    state_reg <= S_RD;
                end else if (cmd_reg == `TOK_CMD_INIT) begin
                    if (o_addr == `TOK_COUNT - 1) begin
                        init_reg    <= 1'b1;
                        o_init_done <= 1'b1;
                        o_owned     <= {`TOK_COUNT{1'b0}};
                        state_reg   <= S_FIN;
                    end else begin
                        o_addr    <= o_addr + 3'h1;
                        state_reg <= S_WR;
                    end
                end else begin
                    o_owned[o_addr] <= 1'b0;
                    state_reg       <= S_FIN;
                end
            end
            S_RD: begin
                o_token_space_select_n <= 1'b0;
                o_oe_n                 <= 1'b0;
                o_rw_n                 <= 1'b1;
                if (cnt_reg == STROBE_CYC[7:0]) begin
                    // zero means ours; one means the other port holds it
                    o_granted       <= ~i_data_in[0];
                    o_owned[o_addr] <= ~i_data_in[0];
                    cnt_reg         <= 8'h00;
                    state_reg       <= S_FIN;
                end else begin
                    cnt_reg <= cnt_reg + 8'h01;
                end
            end
            S_FIN: begin
                o_token_space_select_n <= 1'b1;
                o_oe_n                 <= 1'b1;
                o_busy                 <= 1'b0;
                o_done                 <= init_reg;
                state_reg              <= S_IDLE;
            end
            default: begin
                state_reg <= S_IDLE;
            end
            endcase
        end
    end
endmodule
`default_nettype wire

/* src/token_host_regs.vh */
// constants for the semaphore token host controller
`ifndef TOKEN_HOST_REGS_VH
`define TOKEN_HOST_REGS_VH
`define TOK_COUNT        8
`define TOK_ADDR_W       3
`define TOK_DATA_W       16
`define TOK_CMD_ACQUIRE  2'h0
`define TOK_CMD_RELEASE  2'h1
`define TOK_CMD_INIT     2'h2
`define TOK_CMD_WITHDRAW 2'h3
`define TOK_STROBE_CYC   2
`endif
